// ===== usrt_dev.sv
// Function
// - full duplex serial with flow control, 1 Mbps
// - parity sent and checked in ninth bit
// - each side sends only when partner ready
// - handshake lines are low when asserted
// - data lines idle high between characters
// - transmit pin output, driven high after reset
// - receive pin input, reads idle when open
// - ready pin output, driven low after reset
// - clear pin reads asserted when open
// - receive buffer holds at least six bytes
// - host honours handshake, no looped lines
`timescale 1ns/1ns
`default_nettype none
module usrt_dev
  import usrt_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYC_DEF, // cycles per bit
  parameter int unsigned DEPTH = RX_DEPTH, // receive buffer entries
  parameter int unsigned SLACK = RX_SLACK // free entries at ready drop
) (
  input wire logic clk_i, // system clock
  input wire logic nrst_i, // synchronous reset, low active
  usrt_if.dev lnk, // serial lines to host
  input wire logic par_en_i, // parity enable
  input wire logic par_odd_i, // odd parity when high
  input wire logic [DATA_BITS-1:0] tx_data_i, // byte to send
  input wire logic tx_valid_i, // byte offered
  output logic tx_ready_o, // byte taken this cycle
  output logic [DATA_BITS-1:0] rx_data_o, // oldest received byte
  output logic rx_valid_o, // buffer not empty
  input wire logic rx_ready_i, // user pops oldest byte
  output logic rx_ovf_o, // overflow event pulse
  output logic rx_perr_o, // parity error event pulse
  output logic rx_ferr_o // stop bit error event pulse
);
  localparam int CW = $clog2(BIT_CYC + 1); // bit timer width
  localparam int PW = $clog2(DEPTH); // buffer index width
  localparam int NW = $clog2(DEPTH + 1); // fill count width
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC - 1); // last bit cycle
  localparam logic [CW-1:0] BIT_HALF = CW'(BIT_CYC / 2); // mid bit point
  localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1); // last data index

  // two-stage synchronisers on the pins from the host
  logic rxd_s1_r, rxd_s2_r; // receive data sync stages
  logic cts_s1_r, cts_s2_r; // host ready sync stages
  always_ff @(posedge clk_i) begin
    // a reset value of idle keeps an open line quiet
    if (!nrst_i) begin
      rxd_s1_r <= LINE_IDLE;
      rxd_s2_r <= LINE_IDLE;
      cts_s1_r <= HS_ASSERT;
      cts_s2_r <= HS_ASSERT;
    end else begin
      rxd_s1_r <= lnk.port_pin_twentytwo;
      rxd_s2_r <= rxd_s1_r;
      cts_s1_r <= lnk.port_pin_twentyfour;
      cts_s2_r <= cts_s1_r;
    end
  end
  wire host_ready = (cts_s2_r == HS_ASSERT); // low means go

  // transmitter, free of the receiver so both run at once
  us_state_t tx_st_r; // transmit state
  logic [CW-1:0] tx_cnt_r; // bit timer
  logic [2:0] tx_idx_r; // data bit index
  logic [DATA_BITS-1:0] tx_sh_r; // shift register
  logic tx_par_r; // parity bit to send
  logic tx_pin_r; // transmit pin level
  wire tx_tick = (tx_cnt_r == BIT_LAST); // end of a bit time
  // a byte is only taken while the host is ready
  assign tx_ready_o = (tx_st_r == US_IDLE) && host_ready;
  wire tx_take = tx_ready_o && tx_valid_i;
  wire tx_odd_par = ^tx_data_i ^ par_odd_i; // parity bit of the byte

  // bit timer restarts on each new bit
  always_ff @(posedge clk_i) begin
    if (!nrst_i || tx_st_r == US_IDLE || tx_tick) tx_cnt_r <= '0;
    else tx_cnt_r <= tx_cnt_r + 1'b1;
  end

  // frame sequencer: start, lsb first data, parity, stop
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tx_st_r <= US_IDLE;
      tx_pin_r <= LINE_IDLE; // idle high from reset
      tx_idx_r <= '0;
      tx_sh_r <= '0;
      tx_par_r <= 1'b0;
    end else begin
      unique case (tx_st_r)
        US_IDLE: begin
          tx_pin_r <= LINE_IDLE;
          if (tx_take) begin
            tx_sh_r <= tx_data_i;
            tx_par_r <= tx_odd_par;
            tx_pin_r <= 1'b0; // start bit
            tx_st_r <= US_START;
          end
        end
        US_START: if (tx_tick) begin
          tx_pin_r <= tx_sh_r[0];
          tx_sh_r <= tx_sh_r >> 1;
          tx_idx_r <= '0;
          tx_st_r <= US_DATA;
        end
        US_DATA: if (tx_tick) begin
          if (tx_idx_r == LAST_BIT) begin
            // ninth bit carries parity when enabled
            tx_pin_r <= par_en_i ? tx_par_r : LINE_IDLE;
            tx_st_r <= par_en_i ? US_PAR : US_STOP;
          end else begin
            tx_pin_r <= tx_sh_r[0];
            tx_sh_r <= tx_sh_r >> 1;
            tx_idx_r <= tx_idx_r + 1'b1;
          end
        end
        US_PAR: if (tx_tick) begin
          tx_pin_r <= LINE_IDLE; // stop bit
          tx_st_r <= US_STOP;
        end
        US_STOP: if (tx_tick) tx_st_r <= US_IDLE;
        default: tx_st_r <= US_IDLE;
      endcase
    end
  end
  assign lnk.port_pin_twentyone = tx_pin_r;

  // receiver
  us_state_t rx_st_r; // receive state
  logic [CW-1:0] rx_cnt_r; // bit timer, zero at bit centre
  logic [2:0] rx_idx_r; // data bit index
  logic [DATA_BITS-1:0] rx_sh_r; // shift register
  logic rx_par_r; // running parity
  logic rx_push_r, rx_perr_r, rx_ferr_r; // frame pulses; parity error at the parity bit, one bit before the stop bit pulses
  wire rx_mid = (rx_cnt_r == BIT_LAST); // one bit after last sample
  wire rx_half = (rx_cnt_r == BIT_HALF); // start bit centre

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rx_st_r <= US_IDLE;
      rx_cnt_r <= '0;
      rx_idx_r <= '0;
      rx_sh_r <= '0;
      rx_par_r <= 1'b0;
      rx_push_r <= 1'b0;
      rx_perr_r <= 1'b0;
      rx_ferr_r <= 1'b0;
    end else begin
      rx_push_r <= 1'b0;
      rx_perr_r <= 1'b0;
      rx_ferr_r <= 1'b0;
      rx_cnt_r <= (rx_mid || rx_st_r == US_IDLE) ? '0 : rx_cnt_r + 1'b1;
      unique case (rx_st_r)
        US_IDLE: if (!rxd_s2_r) rx_st_r <= US_START; // falling edge
        US_START: if (rx_half) begin
          rx_cnt_r <= '0; // recentre on the start bit
          // a glitch shorter than half a bit is dropped
          rx_st_r <= rxd_s2_r ? US_IDLE : US_DATA;
          rx_idx_r <= '0;
          rx_par_r <= par_odd_i;
        end
        US_DATA: if (rx_mid) begin
          rx_sh_r <= {rxd_s2_r, rx_sh_r[DATA_BITS-1:1]}; // lsb first
          rx_par_r <= rx_par_r ^ rxd_s2_r;
          rx_idx_r <= rx_idx_r + 1'b1;
          if (rx_idx_r == LAST_BIT) rx_st_r <= par_en_i ? US_PAR : US_STOP;
        end
        US_PAR: if (rx_mid) begin
          rx_perr_r <= rx_par_r ^ rxd_s2_r; // check every char
          rx_st_r <= US_STOP;
        end
        US_STOP: if (rx_mid) begin
          rx_push_r <= 1'b1;
          rx_ferr_r <= !rxd_s2_r; // stop must be high
          rx_st_r <= US_IDLE;
        end
        default: rx_st_r <= US_IDLE;
      endcase
    end
  end

  // receive buffer
  logic [DATA_BITS-1:0] mem_r [DEPTH]; // byte storage
  logic [PW-1:0] wp_r, rp_r; // write and read index
  logic [NW-1:0] fill_r; // bytes held
  logic ovf_r, perr_r, ferr_r; // event outputs
  logic rts_r; // ready pin level
  wire full = (fill_r == NW'(DEPTH));
  wire push = rx_push_r && !full; // full buffer drops byte
  wire pop = rx_valid_o && rx_ready_i;
  wire [PW-1:0] wp_inc = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
  wire [PW-1:0] rp_inc = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
  // ready drops with room left for frames already on the way
  wire room = (fill_r < NW'(DEPTH - SLACK));
  assign rx_valid_o = (fill_r != '0);
  assign rx_data_o = mem_r[rp_r];

  // storage is written only on an accepted byte
  always_ff @(posedge clk_i) begin
    if (push) mem_r[wp_r] <= rx_sh_r;
  end

  // indices, fill, events and the ready pin
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      fill_r <= '0;
      ovf_r <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
      rts_r <= HS_ASSERT; // ready low after reset
    end else begin
      if (push) wp_r <= wp_inc;
      if (pop) rp_r <= rp_inc;
      fill_r <= fill_r + NW'(push) - NW'(pop);
      ovf_r <= rx_push_r && full;
      perr_r <= rx_perr_r;
      ferr_r <= rx_ferr_r;
      rts_r <= room ? HS_ASSERT : HS_DEASSERT;
    end
  end
  assign lnk.port_pin_twentythree = rts_r;
  assign rx_ovf_o = ovf_r;
  assign rx_perr_o = perr_r;
  assign rx_ferr_o = ferr_r;
endmodule : usrt_dev
`default_nettype wire

// ===== usrt_host.sv
`timescale 1ns/1ns
`default_nettype none
// host end: one byte register each way, honours the module's ready
module usrt_host
  import usrt_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYC_DEF // cycles per bit
) (
  input wire logic clk_i, // system clock
  input wire logic nrst_i, // synchronous reset, low active
  usrt_if.host lnk, // serial lines to module
  input wire logic par_en_i, // parity enable
  input wire logic par_odd_i, // odd parity when high
  input wire logic [DATA_BITS-1:0] tx_data_i, // byte to send
  input wire logic tx_valid_i, // byte offered
  output logic tx_ready_o, // byte taken this cycle
  output logic [DATA_BITS-1:0] rx_data_o, // last received byte
  output logic rx_valid_o, // one-cycle byte strobe
  input wire logic rx_hold_i, // user not ready: deassert own ready
  output logic rx_perr_o, // parity error pulse
  output logic rx_ferr_o // stop error pulse
);
  localparam int CW = $clog2(BIT_CYC + 1); // bit timer width
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC - 1); // last bit cycle
  localparam logic [CW-1:0] BIT_HALF = CW'(BIT_CYC / 2); // start centre
  localparam int FW = DATA_BITS + 2; // data, parity, stop bits
  localparam logic [3:0] NBITS_P = 4'(DATA_BITS + 2); // bits after start
  localparam logic [3:0] NBITS_N = 4'(DATA_BITS + 1); // no parity

  // synchronise module pins
  logic rxd_s1_r, rxd_s2_r, rts_s1_r, rts_s2_r; // sync stages
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rxd_s1_r <= LINE_IDLE;
      rxd_s2_r <= LINE_IDLE;
      rts_s1_r <= HS_DEASSERT;
      rts_s2_r <= HS_DEASSERT;
    end else begin
      rxd_s1_r <= lnk.port_pin_twentyone;
      rxd_s2_r <= rxd_s1_r;
      rts_s1_r <= lnk.port_pin_twentythree;
      rts_s2_r <= rts_s1_r;
    end
  end
  // start a frame only while module ready is low
  wire dev_ready = (rts_s2_r == HS_ASSERT);

  // transmitter: one shift register of the frame after the start bit
  logic [FW-1:0] txf_r; // remaining bits, lsb first
  logic [3:0] txn_r; // bits left after current
  logic [CW-1:0] txc_r; // bit timer
  logic txb_r; // busy
  logic txp_r; // pin level
  wire tx_tick = (txc_r == BIT_LAST);
  wire tx_par = ^tx_data_i ^ par_odd_i;
  assign tx_ready_o = !txb_r && dev_ready;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      txf_r <= '1;
      txn_r <= '0;
      txc_r <= '0;
      txb_r <= 1'b0;
      txp_r <= LINE_IDLE;
    end else if (!txb_r) begin
      txc_r <= '0;
      if (tx_valid_i && tx_ready_o) begin
        txb_r <= 1'b1;
        txp_r <= 1'b0; // start bit
        // without parity the ninth slot is the stop bit
        txf_r <= {1'b1, par_en_i ? tx_par : 1'b1, tx_data_i};
        txn_r <= par_en_i ? NBITS_P : NBITS_N;
      end
    end else begin
      txc_r <= tx_tick ? '0 : txc_r + 1'b1;
      if (tx_tick) begin
        if (txn_r == '0) begin
          txb_r <= 1'b0;
          txp_r <= LINE_IDLE;
        end else begin
          txp_r <= txf_r[0];
          txf_r <= {1'b1, txf_r[FW-1:1]};
          txn_r <= txn_r - 1'b1;
        end
      end
    end
  end
  assign lnk.port_pin_twentytwo = txp_r;
  // host ready line, low active
  assign lnk.port_pin_twentyfour = rx_hold_i ? HS_DEASSERT : HS_ASSERT;

  // receiver: sample centres, collect all bits after start
  logic [FW-1:0] rxf_r; // collected bits
  logic [3:0] rxn_r; // bits still to sample
  logic [CW-1:0] rxc_r; // bit timer
  logic rxb_r, rxs_r; // busy, in start bit
  logic [DATA_BITS-1:0] rxd_r; // output byte
  logic rxv_r, rxpe_r, rxfe_r; // output pulses
  wire [FW-1:0] rxf_nxt = {rxd_s2_r, rxf_r[FW-1:1]};
  // align a short frame down to bit zero
  wire [FW-1:0] rxa = par_en_i ? rxf_nxt : {1'b1, rxf_nxt[FW-1:1]};
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rxf_r <= '0;
      rxn_r <= '0;
      rxc_r <= '0;
      rxb_r <= 1'b0;
      rxs_r <= 1'b0;
      rxd_r <= '0;
      rxv_r <= 1'b0;
      rxpe_r <= 1'b0;
      rxfe_r <= 1'b0;
    end else begin
      rxv_r <= 1'b0;
      rxpe_r <= 1'b0;
      rxfe_r <= 1'b0;
      rxc_r <= (!rxb_r || (rxs_r ? rxc_r == BIT_HALF : rxc_r == BIT_LAST))
        ? '0 : rxc_r + 1'b1;
      if (!rxb_r) begin
        if (!rxd_s2_r) begin
          rxb_r <= 1'b1;
          rxs_r <= 1'b1;
          rxn_r <= par_en_i ? NBITS_P : NBITS_N;
        end
      end else if (rxs_r) begin
        if (rxc_r == BIT_HALF) begin
          rxs_r <= 1'b0;
          rxb_r <= !rxd_s2_r; // glitch rejected
        end
      end else if (rxc_r == BIT_LAST) begin
        rxf_r <= rxf_nxt;
        rxn_r <= rxn_r - 1'b1;
        if (rxn_r == 4'h1) begin
          rxb_r <= 1'b0;
          rxd_r <= rxa[DATA_BITS-1:0];
          rxv_r <= 1'b1;
          rxpe_r <= par_en_i && (^rxa[DATA_BITS:0] != par_odd_i);
          // the last sample is the stop bit in both frame lengths
          rxfe_r <= !rxd_s2_r;
        end
      end
    end
  end
  assign rx_data_o = rxd_r;
  assign rx_valid_o = rxv_r;
  assign rx_perr_o = rxpe_r;
  assign rx_ferr_o = rxfe_r;
endmodule : usrt_host
`default_nettype wire

// ===== usrt_if.sv
`timescale 1ns/1ns
`default_nettype none
// the four serial lines between the module and the host
interface usrt_if;
  logic port_pin_twentyone; // module transmit data, toward host
  logic port_pin_twentytwo; // host transmit data, toward module
  logic port_pin_twentythree; // module ready-to-receive, low active
  logic port_pin_twentyfour; // host ready-to-receive, low active
  modport dev (
    output port_pin_twentyone,
    input port_pin_twentytwo,
    output port_pin_twentythree,
    input port_pin_twentyfour
  );
  modport host (
    input port_pin_twentyone,
    output port_pin_twentytwo,
    input port_pin_twentythree,
    output port_pin_twentyfour
  );
endinterface : usrt_if
`default_nettype wire

// ===== usrt_pkg.sv
`default_nettype none
package usrt_pkg;
  // system clock and serial timing
  localparam int unsigned CLK_HZ = 250_000_000; // system clock rate
  localparam int unsigned BAUD_MAX = 1_000_000; // fastest serial rate
  localparam int unsigned BAUD_DEF = 115_200; // default serial rate
  // cycles per bit at the default rate, rounded down
  localparam int unsigned BIT_CYC_DEF = CLK_HZ / BAUD_DEF;
  // cycles per bit at the fastest rate
  localparam int unsigned BIT_CYC_MIN = CLK_HZ / BAUD_MAX;
  localparam int unsigned DATA_BITS = 8; // data bits per character
  localparam int unsigned RX_DEPTH = 6; // receive buffer entries
  localparam int unsigned RX_SLACK = 2; // entries kept free at ready drop
  // pin defaults after reset
  localparam logic LINE_IDLE = 1'b1; // data line idle level
  localparam logic HS_ASSERT = 1'b0; // handshake asserted level
  localparam logic HS_DEASSERT = 1'b1; // handshake deasserted level
  // serial engine states
  typedef enum logic [2:0] {
    US_IDLE = 3'b000,
    US_START = 3'b001,
    US_DATA = 3'b010,
    US_PAR = 3'b011,
    US_STOP = 3'b100
  } us_state_t;
endpackage : usrt_pkg
`default_nettype wire

// ===== usrt_props.sv
`timescale 1ns/1ns
`default_nettype none
// per-line tracker: low run length and frame start detection
module usrt_trk #(
  parameter int unsigned BIT_CYC = 16 // cycles per bit
) (
  input wire logic clk_i, // system clock
  input wire logic nrst_i, // synchronous reset, low active
  input wire logic line_i, // data line watched
  output logic [15:0] lo_o, // current low run length
  output logic start_o // first low sample of a frame
);
  logic [15:0] pos_r; // cycles since frame start
  logic bsy_r; // frame in progress
  logic end_w; // past mid of bit nine with line high
  assign start_o = !line_i && !bsy_r;
  // a low parity bit keeps the frame open, so it is never a new start
  assign end_w = line_i && pos_r >= 16'(9 * BIT_CYC + BIT_CYC / 2);
  // low-run counter and frame window
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      lo_o <= '0;
      pos_r <= '0;
      bsy_r <= 1'b0;
    end else begin
      lo_o <= line_i ? 16'h0000 : lo_o + 16'h0001;
      pos_r <= (start_o || !bsy_r) ? 16'h0001 : pos_r + 16'h0001;
      bsy_r <= start_o || (bsy_r && !end_w);
    end
  end
endmodule : usrt_trk

// wire checks on the link joining the module and host ends
module usrt_props
  import usrt_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYC_DEF // cycles per bit
) (
  input wire logic clk_i, // system clock
  input wire logic nrst_i, // synchronous reset, low active
  input wire logic port_pin_twentyone, // module transmit
  input wire logic port_pin_twentytwo, // host transmit
  input wire logic port_pin_twentythree, // module ready, low active
  input wire logic port_pin_twentyfour // host ready, low active
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic [15:0] dlo, hlo; // low runs on each data line
  logic d_start, h_start; // frame starts on each data line
  logic [3:0] mhi_r, hhi_r; // cycles each ready line stood high
  usrt_trk #(.BIT_CYC(BIT_CYC)) dev_trk_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .line_i(port_pin_twentyone), .lo_o(dlo), .start_o(d_start));
  usrt_trk #(.BIT_CYC(BIT_CYC)) host_trk_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .line_i(port_pin_twentytwo), .lo_o(hlo), .start_o(h_start));
  // saturating high-time counters; sync flops allow a few cycles
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mhi_r <= '0;
      hhi_r <= '0;
    end else begin
      mhi_r <= !port_pin_twentyfour ? 4'h0 : mhi_r + 4'(mhi_r != 4'hF);
      hhi_r <= !port_pin_twentythree ? 4'h0 : hhi_r + 4'(hhi_r != 4'hF);
    end
  end
  sequence start_bit_s(x);
    !x [*8];
  endsequence
  sequence idle_pins_s;
    port_pin_twentyone && port_pin_twentytwo && !port_pin_twentythree;
  endsequence
  chk_reset_pins: assert property (
    $rose(nrst_i) |-> idle_pins_s) else $error("pins not idle after reset");
  chk_dev_start: assert property (
    d_start |-> start_bit_s(port_pin_twentyone))
    else $error("module start bit short");
  chk_host_start: assert property (
    h_start |-> start_bit_s(port_pin_twentytwo))
    else $error("host start bit short");
  chk_dev_bits: assert property (
    $rose(port_pin_twentyone) |-> (dlo % BIT_CYC) == 0)
    else $error("module bit time wrong");
  chk_host_bits: assert property (
    $rose(port_pin_twentytwo) |-> (hlo % BIT_CYC) == 0)
    else $error("host bit time wrong");
  chk_dev_stop: assert property (
    dlo <= 16'(10 * BIT_CYC)) else $error("module line low too long");
  chk_host_stop: assert property (
    hlo <= 16'(10 * BIT_CYC)) else $error("host line low too long");
  chk_dev_flow: assert property (
    d_start |-> mhi_r < 4'h5) else $error("module sent while host busy");
  chk_host_flow: assert property (
    h_start |-> hhi_r < 4'h5) else $error("host sent while module busy");
endmodule : usrt_props
`default_nettype wire

// ===== usrt_tb.sv
`timescale 1ns/1ns
`default_nettype none
// both ends joined; a second module end faces a rule-breaking driver
module usrt_tb
  import usrt_pkg::*;
;
  localparam int unsigned BC = 16; // short bit time keeps the run brief
  typedef struct packed {
    logic pe; // parity enable
    logic po; // odd parity
    logic [7:0] dv; // sent by module, expected at host
    logic [7:0] hv; // sent by host, expected at module
  } usrt_row_t;
  usrt_row_t rows [4] = '{'{1'b0, 1'b0, 8'hA5, 8'h5A},
    '{1'b1, 1'b0, 8'h3C, 8'h01}, '{1'b1, 1'b1, 8'h01, 8'hFE},
    '{1'b1, 1'b0, 8'hFF, 8'h00}};
  logic clk_i = 1'b0, nrst_i = 1'b0, pe = 1'b0, po = 1'b0; // common inputs
  logic [7:0] d_txd = 8'h00, h_txd = 8'h00, h_got = 8'h00; // data bytes
  logic d_txv = 1'b0, h_txv = 1'b0, d_rxr = 1'b0, b_rxr = 1'b0; // strobes
  logic h_hold = 1'b0; // host not ready
  logic [7:0] d_rxd, h_rxd, b_rxd; // received bytes
  logic d_txr, h_txr, d_rxv, h_rxv, b_rxv; // handshakes
  logic d_ovf, d_perr, d_ferr, h_perr, h_ferr, b_ovf, b_perr, b_ferr;
  int compares = 0, num_errors = 0; // verdict tallies
  int h_n = 0, h_bad = 0, d_bad = 0, b_ovf_n = 0, b_perr_n = 0, b_ferr_n = 0;
  usrt_if lnk(); // module end to host end
  usrt_if lnk2(); // second module end to the raw driver
  usrt_dev #(.BIT_CYC(BC)) usrt_dev_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .lnk(lnk), .par_en_i(pe), .par_odd_i(po), .tx_data_i(d_txd),
    .tx_valid_i(d_txv), .tx_ready_o(d_txr), .rx_data_o(d_rxd),
    .rx_valid_o(d_rxv), .rx_ready_i(d_rxr), .rx_ovf_o(d_ovf),
    .rx_perr_o(d_perr), .rx_ferr_o(d_ferr));
  usrt_host #(.BIT_CYC(BC)) usrt_host_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .lnk(lnk), .par_en_i(pe), .par_odd_i(po), .tx_data_i(h_txd),
    .tx_valid_i(h_txv), .tx_ready_o(h_txr), .rx_data_o(h_rxd),
    .rx_valid_o(h_rxv), .rx_hold_i(h_hold), .rx_perr_o(h_perr),
    .rx_ferr_o(h_ferr));
  usrt_dev #(.BIT_CYC(BC)) usrt_dev_b_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .lnk(lnk2), .par_en_i(1'b1), .par_odd_i(1'b0), .tx_data_i(8'h00),
    .tx_valid_i(1'b0), .tx_ready_o(), .rx_data_o(b_rxd),
    .rx_valid_o(b_rxv), .rx_ready_i(b_rxr), .rx_ovf_o(b_ovf),
    .rx_perr_o(b_perr), .rx_ferr_o(b_ferr));
  usrt_props #(.BIT_CYC(BC)) usrt_props_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .port_pin_twentyone(lnk.port_pin_twentyone),
    .port_pin_twentytwo(lnk.port_pin_twentytwo),
    .port_pin_twentythree(lnk.port_pin_twentythree),
    .port_pin_twentyfour(lnk.port_pin_twentyfour));
  always #2 clk_i = ~clk_i;
  // tallies sampled mid-cycle, where one-cycle pulses are settled
  always @(negedge clk_i) begin
    if (h_rxv === 1'b1) begin
      h_got = h_rxd;
      h_n++;
    end
    h_bad += int'(h_perr !== 1'b0 || h_ferr !== 1'b0);
    d_bad += int'(d_ovf !== 1'b0 || d_perr !== 1'b0 || d_ferr !== 1'b0);
    b_ovf_n += int'(b_ovf === 1'b1);
    b_perr_n += int'(b_perr === 1'b1);
    b_ferr_n += int'(b_ferr === 1'b1);
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // offer one byte at either end, held until taken
  task automatic send(input logic h, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    if (h) {h_txd, h_txv} <= {d, 1'b1};
    else {d_txd, d_txv} <= {d, 1'b1};
    do begin
      @(negedge clk_i);
      n++;
    end while ((h ? h_txr : d_txr) !== 1'b1 && n < 3000);
    @(posedge clk_i);
    if (h) h_txv <= 1'b0;
    else d_txv <= 1'b0;
    if (n >= 3000) check(16'h0000, 16'h0001);
  endtask : send
  // wait for a buffered byte, compare it, pop it
  task automatic take(input logic b, input logic [7:0] e);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while ((b ? b_rxv : d_rxv) !== 1'b1 && n < 3000);
    check(16'(b ? b_rxd : d_rxd), 16'(e));
    @(posedge clk_i);
    if (b) b_rxr <= 1'b1;
    else d_rxr <= 1'b1;
    @(posedge clk_i);
    {b_rxr, d_rxr} <= 2'b00;
  endtask : take
  task automatic wait_host(input int n0);
    int n;
    n = 0;
    while (h_n == n0 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    check(16'(h_n - n0), 16'h0001);
  endtask : wait_host
  // sample the module's frame at mid-bit against the expected pattern
  task automatic watch(input logic [7:0] d);
    logic [10:0] f;
    // built after the start edge, once the row's parity settings stand
    @(negedge lnk.port_pin_twentyone);
    f = {1'b1, pe ? ^d ^ po : 1'b1, d, 1'b0};
    repeat (BC / 2) @(negedge clk_i);
    for (int i = 0; i < 10 + int'(pe); i++) begin
      check(16'(lnk.port_pin_twentyone), 16'(f[i]));
      repeat (BC) @(negedge clk_i);
    end
  endtask : watch
  // raw host that ignores ready; bad parity or bad stop on request
  task automatic raw(input logic [7:0] d, input logic pb, input logic sb);
    logic [10:0] f;
    f = {~sb, ^d ^ pb, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_i);
      lnk2.port_pin_twentytwo <= f[i];
      repeat (BC - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    lnk2.port_pin_twentytwo <= 1'b1;
    repeat (2 * BC) @(posedge clk_i);
  endtask : raw
  task automatic summarize();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
  initial begin
    int hn;
    int n;
    lnk2.port_pin_twentytwo = 1'b1;
    lnk2.port_pin_twentyfour = 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    check(16'(lnk.port_pin_twentyone), 16'h0001);
    check(16'(lnk.port_pin_twentythree), 16'h0000);
    check(16'(d_rxv), 16'h0000);
    repeat (4) @(posedge clk_i);
    foreach (rows[k]) begin
      {pe, po} <= {rows[k].pe, rows[k].po};
      hn = h_n;
      fork
        send(1'b0, rows[k].dv);
        send(1'b1, rows[k].hv);
        watch(rows[k].dv);
      join
      take(1'b0, rows[k].hv);
      wait_host(hn);
      check(16'(h_got), 16'(rows[k].dv));
    end
    check(16'(h_bad + d_bad), 16'h0000);
    // host not ready: the module must hold its byte back
    @(posedge clk_i);
    h_hold <= 1'b1;
    hn = h_n;
    repeat (4) @(negedge clk_i);
    check(16'(d_txr), 16'h0000);
    fork
      send(1'b0, 8'h5A);
    join_none
    repeat (100) @(negedge clk_i);
    check(16'(lnk.port_pin_twentyone), 16'h0001);
    @(posedge clk_i);
    h_hold <= 1'b0;
    wait_host(hn);
    check(16'(h_got), 16'h005A);
    // burst from an honest host: ready drops early, nothing lost
    fork
      for (int j = 0; j < 6; j++) send(1'b1, 8'hC0 + 8'(j));
    join_none
    n = 0;
    while (lnk.port_pin_twentythree !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    repeat (400) @(negedge clk_i);
    check(16'(lnk.port_pin_twentythree), 16'h0001);
    check(16'(d_bad), 16'h0000);
    for (int j = 0; j < 6; j++) take(1'b0, 8'hC0 + 8'(j));
    // host breaking the handshake: six held, seventh overflows
    for (int j = 0; j < 6; j++) raw(8'h10 + 8'(j), 1'b0, 1'b0);
    check(16'(lnk2.port_pin_twentythree), 16'h0001);
    check(16'(b_ovf_n), 16'h0000);
    raw(8'hEE, 1'b0, 1'b0);
    check(16'(b_ovf_n), 16'h0001);
    for (int j = 0; j < 6; j++) take(1'b1, 8'h10 + 8'(j));
    raw(8'h81, 1'b1, 1'b0);
    take(1'b1, 8'h81);
    check(16'(b_perr_n), 16'h0001);
    raw(8'h42, 1'b0, 1'b1);
    take(1'b1, 8'h42);
    check(16'(b_ferr_n), 16'h0001);
    // mid-run reset: a held byte is dropped, pins return to defaults
    raw(8'h33, 1'b0, 1'b0);
    check(16'(b_rxv), 16'h0001);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    check(16'(b_rxv), 16'h0000);
    check(16'(lnk.port_pin_twentyone), 16'h0001);
    check(16'(lnk.port_pin_twentythree), 16'h0000);
    check(16'(lnk2.port_pin_twentythree), 16'h0000);
    summarize();
  end
endmodule : usrt_tb
`default_nettype wire
